// File: verilog/pin_mux_pkg.sv
//==========================================================
package pin_mux_pkg;

  //==========================================================
  // function select codes, one two-bit field per pin
  localparam logic [1:0] SEL_GPIO   = 2'h0;
  localparam logic [1:0] SEL_FUNC_A = 2'h1;
  localparam logic [1:0] SEL_FUNC_B = 2'h2;
  localparam logic [1:0] SEL_FUNC_C = 2'h3;

  //==========================================================
  // management channel modes
  localparam logic [1:0] MGMT_UART   = 2'h0;
  localparam logic [1:0] MGMT_TRANSP = 2'h1;
  localparam logic [1:0] MGMT_GCI    = 2'h2;

  //==========================================================
  // inactive / reset levels
  localparam logic IDLE_SERIAL  = 1'h1;  // serial line marks high
  localparam logic IDLE_LOW_ACT = 1'h1;  // active-low inputs idle high
  localparam logic IDLE_HIGH_ACT = 1'h0;
  localparam int   SYNC_STAGES  = 2;
  localparam int   PIN_COUNT    = 5;

endpackage : pin_mux_pkg

// File: verilog/port_c_d_pin_function_mux.sv
`timescale 1ns/100ps
module port_c_d_pin_function_mux #(
  parameter int STROBES = 2
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  // pads: input, output, output enable
  input  wire logic               port_c_bit_five_in,
  output logic                    port_c_bit_five_out,
  output logic                    port_c_bit_five_oe,
  input  wire logic               port_c_bit_four_in,
  output logic                    port_c_bit_four_out,
  output logic                    port_c_bit_four_oe,
  input  wire logic               port_d_bit_thirtyone_in,
  output logic                    port_d_bit_thirtyone_out,
  output logic                    port_d_bit_thirtyone_oe,
  input  wire logic               port_d_bit_thirty_in,
  output logic                    port_d_bit_thirty_out,
  output logic                    port_d_bit_thirty_oe,
  input  wire logic               port_d_bit_twentynine_in,
  output logic                    port_d_bit_twentynine_out,
  output logic                    port_d_bit_twentynine_oe,
  // per-pin select and general-purpose control, bit order c5 c4 d31 d30 d29
  input  wire logic [1:0]         sel_c5,
  input  wire logic [1:0]         sel_c4,
  input  wire logic [1:0]         sel_d31,
  input  wire logic [1:0]         sel_d30,
  input  wire logic [1:0]         sel_d29,
  input  wire logic [4:0]         gpio_out,
  input  wire logic [4:0]         gpio_dir,
  output logic      [4:0]         gpio_in,
  // management serial channel one
  input  wire logic [1:0]         mgmt_mode,
  input  wire logic               mgmt_tx_data,
  output logic                    mgmt_rx_data,
  input  wire logic               mgmt_sync_pad,
  output logic                    mgmt_sync_in,
  // slot strobes three and four of serial_iface_two
  input  wire logic [STROBES-1:0] strobe_byte_mode,
  input  wire logic [STROBES-1:0] strobe_bit_tick,
  input  wire logic [STROBES-1:0] strobe_slot_active,
  // fast_ctrl_two modem inputs, active low, synchronised
  output logic                    fast_ctrl_two_cts_n,
  output logic                    fast_ctrl_two_cd_n,
  // comm_chan_one
  input  wire logic               comm_tx_data,
  output logic                    comm_rx_data,
  input  wire logic               comm_rts_n,
  input  wire logic               comm_eth_mode,
  input  wire logic               eth_tx_enable,
  input  wire logic               comm_cts_n_pad,
  output logic                    comm_req_granted,
  // DMA handshake sets one and two
  input  wire logic               dma_req_ack_one,
  input  wire logic               dma_done_one_out,
  input  wire logic               dma_done_one_oe,
  output logic                    dma_done_one_in,
  input  wire logic               dma_req_ack_two,
  input  wire logic               dma_done_two_out,
  input  wire logic               dma_done_two_oe,
  output logic                    dma_done_two_in,
  // fast_ctrl_one cell interface
  input  wire logic               utopia_master,
  input  wire logic               cell_rx_addr_bit3_out,
  output logic                    cell_rx_addr_bit3_in,
  output logic                    cell_rx_avail_two
);

  //==========================================================
  // slot strobe shaping
  function automatic logic strobe_level(input logic byte_mode, input logic tick,
                                        input logic active);
    strobe_level = active & (byte_mode | tick);
  endfunction : strobe_level

  logic [STROBES-1:0] strobe_q;
  always_comb begin
    for (int i = 0; i < STROBES; i++) begin
      strobe_q[i] = strobe_level(strobe_byte_mode[i], strobe_bit_tick[i],
                                 strobe_slot_active[i]);
    end
  end

  //==========================================================
  // pad outputs
  logic [4:0] pad_out_r, pad_out_nxt;
  logic [4:0] pad_oe_r,  pad_oe_nxt;

  always_comb begin
    pad_out_nxt = gpio_out;
    pad_oe_nxt  = gpio_dir;
    // port C bit five
    case (sel_c5)
      pin_mux_pkg::SEL_FUNC_A: begin
        pad_out_nxt[4] = mgmt_tx_data;
        pad_oe_nxt[4]  = 1'b1;
      end
      pin_mux_pkg::SEL_FUNC_B: begin
        pad_out_nxt[4] = strobe_q[0];
        pad_oe_nxt[4]  = 1'b1;
      end
      pin_mux_pkg::SEL_FUNC_C: pad_oe_nxt[4] = 1'b0;
      default: ;
    endcase
    // port C bit four
    case (sel_c4)
      pin_mux_pkg::SEL_FUNC_A: pad_oe_nxt[3] = 1'b0;
      pin_mux_pkg::SEL_FUNC_B: begin
        pad_out_nxt[3] = strobe_q[STROBES-1];
        pad_oe_nxt[3]  = 1'b1;
      end
      pin_mux_pkg::SEL_FUNC_C: pad_oe_nxt[3] = 1'b0;
      default: ;
    endcase
    // port D bit 31; one select field makes ack and done exclusive
    case (sel_d31)
      pin_mux_pkg::SEL_FUNC_A: pad_oe_nxt[2] = 1'b0;
      pin_mux_pkg::SEL_FUNC_B: begin
        pad_out_nxt[2] = dma_req_ack_one;
        pad_oe_nxt[2]  = 1'b1;
      end
      pin_mux_pkg::SEL_FUNC_C: begin
        pad_out_nxt[2] = dma_done_one_out;
        pad_oe_nxt[2]  = dma_done_one_oe;
      end
      default: ;
    endcase
    // port D bit 30
    case (sel_d30)
      pin_mux_pkg::SEL_FUNC_A: begin
        pad_out_nxt[1] = comm_tx_data;
        pad_oe_nxt[1]  = 1'b1;
      end
      pin_mux_pkg::SEL_FUNC_B: begin
        pad_out_nxt[1] = dma_req_ack_two;
        pad_oe_nxt[1]  = 1'b1;
      end
      pin_mux_pkg::SEL_FUNC_C: begin
        pad_out_nxt[1] = dma_done_two_out;
        pad_oe_nxt[1]  = dma_done_two_oe;
      end
      default: ;
    endcase
    // port D bit 29
    case (sel_d29)
      pin_mux_pkg::SEL_FUNC_A: begin
        pad_out_nxt[0] = comm_eth_mode ? eth_tx_enable : comm_rts_n;
        pad_oe_nxt[0]  = 1'b1;
      end
      pin_mux_pkg::SEL_FUNC_B: begin
        pad_out_nxt[0] = cell_rx_addr_bit3_out;
        pad_oe_nxt[0]  = utopia_master;
      end
      pin_mux_pkg::SEL_FUNC_C: pad_oe_nxt[0] = 1'b0;
      default: ;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pad_out_r <= 5'h00;
      pad_oe_r  <= 5'h00;
    end else begin
      pad_out_r <= pad_out_nxt;
      pad_oe_r  <= pad_oe_nxt;
    end
  end

  assign port_c_bit_five_out       = pad_out_r[4];
  assign port_c_bit_five_oe        = pad_oe_r[4];
  assign port_c_bit_four_out       = pad_out_r[3];
  assign port_c_bit_four_oe        = pad_oe_r[3];
  assign port_d_bit_thirtyone_out  = pad_out_r[2];
  assign port_d_bit_thirtyone_oe   = pad_oe_r[2];
  assign port_d_bit_thirty_out     = pad_out_r[1];
  assign port_d_bit_thirty_oe      = pad_oe_r[1];
  assign port_d_bit_twentynine_out = pad_out_r[0];
  assign port_d_bit_twentynine_oe  = pad_oe_r[0];

  //==========================================================
  // peripheral inputs, idle level when not selected
  logic [4:0] pad_in;
  assign pad_in = {port_c_bit_five_in, port_c_bit_four_in, port_d_bit_thirtyone_in,
                   port_d_bit_thirty_in, port_d_bit_twentynine_in};

  // one bit per peripheral input, order as in the assigns below
  logic [6:0] per_in_r, per_in_nxt;
  logic [4:0] gpio_in_r;

  always_comb begin
    per_in_nxt[0] = (sel_c4 == pin_mux_pkg::SEL_FUNC_A) ? pad_in[3]
                  : pin_mux_pkg::IDLE_SERIAL;
    // sync is unused in UART mode, so hold it idle there
    per_in_nxt[1] = (mgmt_mode != pin_mux_pkg::MGMT_UART) ? mgmt_sync_pad
                  : pin_mux_pkg::IDLE_HIGH_ACT;
    per_in_nxt[2] = (sel_d31 == pin_mux_pkg::SEL_FUNC_A) ? pad_in[2]
                  : pin_mux_pkg::IDLE_SERIAL;
    per_in_nxt[3] = (sel_d31 == pin_mux_pkg::SEL_FUNC_C && !dma_done_one_oe) ? pad_in[2]
                  : pin_mux_pkg::IDLE_LOW_ACT;
    per_in_nxt[4] = (sel_d30 == pin_mux_pkg::SEL_FUNC_C && !dma_done_two_oe) ? pad_in[1]
                  : pin_mux_pkg::IDLE_LOW_ACT;
    per_in_nxt[5] = (sel_d29 == pin_mux_pkg::SEL_FUNC_B && !utopia_master) ? pad_in[0]
                  : pin_mux_pkg::IDLE_HIGH_ACT;
    per_in_nxt[6] = (sel_d29 == pin_mux_pkg::SEL_FUNC_C) ? pad_in[0]
                  : pin_mux_pkg::IDLE_HIGH_ACT;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      per_in_r  <= 7'h1D;
      gpio_in_r <= 5'h00;
    end else begin
      per_in_r  <= per_in_nxt;
      gpio_in_r <= pad_in;
    end
  end

  assign mgmt_rx_data         = per_in_r[0];
  assign mgmt_sync_in         = per_in_r[1];
  assign comm_rx_data         = per_in_r[2];
  assign dma_done_one_in      = per_in_r[3];
  assign dma_done_two_in      = per_in_r[4];
  assign cell_rx_addr_bit3_in = per_in_r[5];
  assign cell_rx_avail_two    = per_in_r[6];
  assign gpio_in              = gpio_in_r;

  //==========================================================
  // synchronisers for asynchronous modem inputs
  // first stage feeds only the second; gating happens before it
  logic [2:0] meta_r,  meta_nxt;
  logic [2:0] stab_r;

  always_comb begin
    meta_nxt[0] = (sel_c5 == pin_mux_pkg::SEL_FUNC_C) ? pad_in[4]
                : pin_mux_pkg::IDLE_LOW_ACT;
    meta_nxt[1] = (sel_c4 == pin_mux_pkg::SEL_FUNC_C) ? pad_in[3]
                : pin_mux_pkg::IDLE_LOW_ACT;
    meta_nxt[2] = comm_cts_n_pad;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= 3'h7;
      stab_r <= 3'h7;
    end else begin
      meta_r <= meta_nxt;
      stab_r <= meta_r;
    end
  end

  assign fast_ctrl_two_cts_n = stab_r[0];
  assign fast_ctrl_two_cd_n  = stab_r[1];

  logic grant_r, grant_nxt;
  always_comb grant_nxt = !comm_rts_n && !stab_r[2];
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) grant_r <= 1'b0;
    else         grant_r <= grant_nxt;
  end
  assign comm_req_granted = grant_r;

  //==========================================================
  // checks
  sequence cts_selected_s;
    sel_c5 == pin_mux_pkg::SEL_FUNC_C;
  endsequence

  a_cts_sync_delay: assert property (@(posedge core_clk) disable iff (sys_rst)
    cts_selected_s ##0 1'b1 |-> ##2 (fast_ctrl_two_cts_n == $past(port_c_bit_five_in, 2)))
    else $error("cts sync delay wrong");

  a_c5_tx_out: assert property (@(posedge core_clk) disable iff (sys_rst)
    sel_c5 == pin_mux_pkg::SEL_FUNC_A |=> port_c_bit_five_oe &&
      port_c_bit_five_out == $past(mgmt_tx_data))
    else $error("c5 tx data not driven");

  a_strobe_byte: assert property (@(posedge core_clk) disable iff (sys_rst)
    sel_c4 == pin_mux_pkg::SEL_FUNC_B && strobe_byte_mode[STROBES-1] &&
      strobe_slot_active[STROBES-1] |=> port_c_bit_four_out && port_c_bit_four_oe)
    else $error("byte strobe not asserted");

  a_done_dir: assert property (@(posedge core_clk) disable iff (sys_rst)
    sel_d31 == pin_mux_pkg::SEL_FUNC_C |=> port_d_bit_thirtyone_oe == $past(dma_done_one_oe)
      && port_d_bit_thirtyone_out == $past(dma_done_one_out))
    else $error("done pin ownership wrong");

  a_ack_two_out: assert property (@(posedge core_clk) disable iff (sys_rst)
    sel_d30 == pin_mux_pkg::SEL_FUNC_B |=> port_d_bit_thirty_oe &&
      port_d_bit_thirty_out == $past(dma_req_ack_two))
    else $error("ack two not on pin");

  a_rts_eth_tx_enable_pick: assert property (@(posedge core_clk) disable iff (sys_rst)
    sel_d29 == pin_mux_pkg::SEL_FUNC_A |=> port_d_bit_twentynine_out ==
      ($past(comm_eth_mode) ? $past(eth_tx_enable) : $past(comm_rts_n)))
    else $error("rts or tx enable wrong");

  a_addr3_dir: assert property (@(posedge core_clk) disable iff (sys_rst)
    sel_d29 == pin_mux_pkg::SEL_FUNC_B |=> port_d_bit_twentynine_oe == $past(utopia_master))
    else $error("addr bit 3 direction wrong");

  a_clav_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    sel_d29 != pin_mux_pkg::SEL_FUNC_C |=> !cell_rx_avail_two)
    else $error("unselected clav not idle");

  a_grant_needs_cts: assert property (@(posedge core_clk) disable iff (sys_rst)
    comm_req_granted |-> $past(!comm_rts_n) && $past(comm_cts_n_pad, 3) == 1'b0)
    else $error("grant without cts");

endmodule : port_c_d_pin_function_mux

// File: verif/far_side_model.sv
`timescale 1ns/100ps
module far_side_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // device pad side, bit4 c5 down to bit0 d29
  input  wire logic [4:0] dev_out,
  input  wire logic [4:0] dev_oe,
  output logic      [4:0] pad,
  // bench commands
  input  wire logic [4:0] drv_val,
  input  wire logic [4:0] drv_en,
  input  wire logic [1:0] grant_delay,
  input  wire logic       rts_on_pad,
  output logic            cts_n
);
  logic [4:0] last_r;
  logic [1:0] wait_r;

  //==========================================================
  // pad resolution
  // no pulls here: a floating pin toggles so a stale level never passes
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (dev_oe[i])
        pad[i] = dev_out[i];
      else if (drv_en[i])
        pad[i] = drv_val[i];
      else
        pad[i] = ~last_r[i];
    end
  end

  //==========================================================
  // remote receiver answering request to send
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_r <= 5'h00;
      wait_r <= 2'h0;
      cts_n  <= 1'h1;
    end else begin
      last_r <= pad;
      if (rts_on_pad && !pad[0]) begin
        if (wait_r == grant_delay)
          cts_n <= 1'h0;
        else
          wait_r <= wait_r + 2'h1;
      end else begin
        wait_r <= 2'h0;
        cts_n  <= 1'h1;
      end
    end
  end
endmodule : far_side_model

// File: verif/port_c_d_pin_function_mux_tb.sv
`timescale 1ns/100ps
module port_c_d_pin_function_mux_tb;
  logic core_clk, sys_rst, utopia_master, cell_rx_addr_bit3_out, cell_rx_addr_bit3_in;
  logic port_c_bit_five_in, port_c_bit_five_out, port_c_bit_five_oe, port_c_bit_four_in;
  logic port_c_bit_four_out, port_c_bit_four_oe, port_d_bit_thirtyone_in;
  logic port_d_bit_thirtyone_out, port_d_bit_thirtyone_oe, port_d_bit_thirty_in;
  logic port_d_bit_thirty_out, port_d_bit_thirty_oe, port_d_bit_twentynine_in;
  logic port_d_bit_twentynine_out, port_d_bit_twentynine_oe, cell_rx_avail_two;
  logic [1:0] sel_c5, sel_c4, sel_d31, sel_d30, sel_d29, mgmt_mode, grant_delay;
  logic [1:0] strobe_byte_mode, strobe_bit_tick, strobe_slot_active;
  logic [4:0] gpio_out, gpio_dir, gpio_in, pad, drv_val, drv_en, pin_out, pin_oe;
  logic mgmt_tx_data, mgmt_rx_data, mgmt_sync_pad, mgmt_sync_in, fast_ctrl_two_cts_n;
  logic fast_ctrl_two_cd_n, comm_tx_data, comm_rx_data, comm_rts_n, comm_eth_mode;
  logic eth_tx_enable, comm_cts_n_pad, comm_req_granted, rts_on_pad;
  logic dma_req_ack_one, dma_done_one_out, dma_done_one_oe, dma_done_one_in;
  logic dma_req_ack_two, dma_done_two_out, dma_done_two_oe, dma_done_two_in;
  int   errors, n_checks;

  assign {port_c_bit_five_in, port_c_bit_four_in, port_d_bit_thirtyone_in,
          port_d_bit_thirty_in, port_d_bit_twentynine_in} = pad;
  assign pin_out = {port_c_bit_five_out, port_c_bit_four_out, port_d_bit_thirtyone_out,
                    port_d_bit_thirty_out, port_d_bit_twentynine_out};
  assign pin_oe = {port_c_bit_five_oe, port_c_bit_four_oe, port_d_bit_thirtyone_oe,
                   port_d_bit_thirty_oe, port_d_bit_twentynine_oe};

  port_c_d_pin_function_mux #(.STROBES(2)) uut (.core_clk, .sys_rst, .port_c_bit_five_in,
    .port_c_bit_five_out, .port_c_bit_five_oe, .port_c_bit_four_in, .port_c_bit_four_out,
    .port_c_bit_four_oe, .port_d_bit_thirtyone_in, .port_d_bit_thirtyone_out,
    .port_d_bit_thirtyone_oe, .port_d_bit_thirty_in, .port_d_bit_thirty_out,
    .port_d_bit_thirty_oe, .port_d_bit_twentynine_in, .port_d_bit_twentynine_out,
    .port_d_bit_twentynine_oe, .sel_c5, .sel_c4, .sel_d31, .sel_d30, .sel_d29, .gpio_out,
    .gpio_dir, .gpio_in, .mgmt_mode, .mgmt_tx_data, .mgmt_rx_data, .mgmt_sync_pad,
    .mgmt_sync_in, .strobe_byte_mode, .strobe_bit_tick, .strobe_slot_active,
    .fast_ctrl_two_cts_n, .fast_ctrl_two_cd_n, .comm_tx_data, .comm_rx_data, .comm_rts_n,
    .comm_eth_mode, .eth_tx_enable, .comm_cts_n_pad, .comm_req_granted, .dma_req_ack_one,
    .dma_done_one_out, .dma_done_one_oe, .dma_done_one_in, .dma_req_ack_two,
    .dma_done_two_out, .dma_done_two_oe, .dma_done_two_in, .utopia_master,
    .cell_rx_addr_bit3_out, .cell_rx_addr_bit3_in, .cell_rx_avail_two);

  far_side_model far (.core_clk, .sys_rst, .dev_out(pin_out), .dev_oe(pin_oe), .pad,
    .drv_val, .drv_en, .grant_delay, .rts_on_pad, .cts_n(comm_cts_n_pad));

  //==========================================================
  // helpers
  always #25 core_clk = ~core_clk;

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  //==========================================================
  // scenarios
  task automatic t_port_c;
    {sel_c5, sel_c4} = {2{pin_mux_pkg::SEL_FUNC_A}};
    drv_en = 5'h08;
    for (int v = 0; v < 2; v++) begin
      mgmt_tx_data = v[0];
      drv_val = v[0] ? 5'h00 : 5'h08;
      cyc(1);
      check({pin_oe[4:3], pin_out[4], mgmt_rx_data}, {2'h2, v[0], ~v[0]});
    end
    {sel_c5, sel_c4} = {2{pin_mux_pkg::SEL_FUNC_B}};
    for (int k = 0; k < 8; k++) begin
      strobe_byte_mode = {~k[0], k[0]};
      strobe_bit_tick = {~k[1], k[1]};
      strobe_slot_active = {2{k[2]}};
      cyc(1);
      check({pin_oe[4:3], pin_out[4:3]},
            {2'h3, k[2] & (k[0] | k[1]), k[2] & (~k[0] | ~k[1])});
    end
    {sel_c5, sel_c4} = {2{pin_mux_pkg::SEL_FUNC_C}};
    drv_en = 5'h18;
    drv_val = 5'h08;
    cyc(3);
    check({pin_oe[4:3], fast_ctrl_two_cts_n, fast_ctrl_two_cd_n}, 4'h1);
    drv_val = 5'h10;
    cyc(1);
    check({fast_ctrl_two_cts_n, fast_ctrl_two_cd_n}, 2'h1);
    cyc(1);
    check({fast_ctrl_two_cts_n, fast_ctrl_two_cd_n}, 2'h2);
    {sel_c5, sel_c4} = {2{pin_mux_pkg::SEL_GPIO}};
    cyc(2);
    check({fast_ctrl_two_cts_n, fast_ctrl_two_cd_n, mgmt_rx_data}, 3'h7);
  endtask : t_port_c

  task automatic t_port_d_dma;
    {sel_d31, sel_d30} = {2{pin_mux_pkg::SEL_FUNC_A}};
    drv_en = 5'h04;
    drv_val = 5'h00;
    comm_tx_data = 1'h1;
    cyc(2);
    check({pin_oe[2:1], pin_out[1], comm_rx_data}, 4'h6);
    {sel_d31, sel_d30} = {2{pin_mux_pkg::SEL_FUNC_B}};
    {dma_req_ack_one, dma_req_ack_two, dma_done_one_out, dma_done_two_out} = 4'h9;
    {dma_done_one_oe, dma_done_two_oe} = 2'h3;
    cyc(1);
    check({pin_oe[2:1], pin_out[2:1]}, 4'hE);
    {sel_d31, sel_d30} = {2{pin_mux_pkg::SEL_FUNC_C}};
    cyc(1);
    check({pin_oe[2:1], pin_out[2:1], dma_done_one_in, dma_done_two_in}, 6'h37);
    {dma_done_one_oe, dma_done_two_oe} = 2'h0;
    drv_en = 5'h06;
    drv_val = 5'h02;
    cyc(2);
    check({pin_oe[2:1], dma_done_one_in, dma_done_two_in}, 4'h1);
  endtask : t_port_d_dma

  task automatic t_d29;
    sel_d29 = pin_mux_pkg::SEL_FUNC_A;
    cyc(1);
    check({pin_oe[0], pin_out[0]}, 2'h3);
    comm_eth_mode = 1'h1;
    cyc(1);
    check({pin_oe[0], pin_out[0]}, 2'h2);
    // flip both sources so only the ethernet pick can give a high pin
    eth_tx_enable = 1'h1;
    comm_rts_n = 1'h0;
    cyc(1);
    check({pin_oe[0], pin_out[0]}, 2'h3);
    eth_tx_enable = 1'h0;
    comm_rts_n = 1'h1;
    comm_eth_mode = 1'h0;
    sel_d29 = pin_mux_pkg::SEL_FUNC_B;
    {utopia_master, cell_rx_addr_bit3_out} = 2'h3;
    cyc(1);
    check({pin_oe[0], pin_out[0]}, 2'h3);
    utopia_master = 1'h0;
    drv_en = 5'h01;
    drv_val = 5'h01;
    cyc(2);
    check({pin_oe[0], cell_rx_addr_bit3_in, cell_rx_avail_two}, 3'h2);
    sel_d29 = pin_mux_pkg::SEL_FUNC_C;
    cyc(1);
    check({pin_oe[0], cell_rx_addr_bit3_in, cell_rx_avail_two}, 3'h1);
    drv_val = 5'h00;
    cyc(1);
    check(cell_rx_avail_two, 1'h0);
  endtask : t_d29

  task automatic t_gpio_sync;
    {sel_c5, sel_c4, sel_d31, sel_d30, sel_d29} = 10'h000;
    {gpio_dir, gpio_out, drv_en, drv_val} = {5'h15, 5'h11, 5'h0A, 5'h08};
    cyc(2);
    check({pin_oe, pin_out & 5'h15}, 10'h2B1);
    check(gpio_in, 5'h19);
    mgmt_sync_pad = 1'h1;
    for (int m = 0; m < 3; m++) begin
      mgmt_mode = m[1:0];
      cyc(1);
      check(mgmt_sync_in, m != 0);
    end
  endtask : t_gpio_sync

  // prompt and slow remote receiver
  task automatic t_grant;
    int n;
    sel_d29 = pin_mux_pkg::SEL_FUNC_A;
    rts_on_pad = 1'h1;
    cyc(6);
    for (int d = 0; d < 4; d += 3) begin
      grant_delay = d[1:0];
      comm_rts_n = 1'h0;
      n = 0;
      while (comm_req_granted !== 1'h1 && n < 20) begin
        cyc(1);
        n++;
      end
      check(n, d + 5);
      comm_rts_n = 1'h1;
      cyc(1);
      check(comm_req_granted, 1'h0);
      cyc(6);
    end
  endtask : t_grant

  //==========================================================
  // main sequence and watchdog
  initial begin
    {core_clk, sys_rst, errors, n_checks} = {2'h1, 64'h0};
    core_clk = 1'h0;
    {sel_c5, sel_c4, sel_d31, sel_d30, sel_d29, mgmt_mode, grant_delay} = 14'h0000;
    {gpio_out, gpio_dir, drv_val, drv_en} = 20'h00000;
    {strobe_byte_mode, strobe_bit_tick, strobe_slot_active} = 6'h00;
    {mgmt_tx_data, mgmt_sync_pad, comm_tx_data, comm_rts_n, comm_eth_mode} = 5'h02;
    {eth_tx_enable, rts_on_pad, utopia_master, cell_rx_addr_bit3_out} = 4'h0;
    {dma_req_ack_one, dma_done_one_out, dma_done_one_oe} = 3'h0;
    {dma_req_ack_two, dma_done_two_out, dma_done_two_oe} = 3'h0;
    cyc(2);
    check({pin_oe, pin_out}, 10'h000);
    check({mgmt_rx_data, fast_ctrl_two_cts_n, fast_ctrl_two_cd_n, comm_rx_data,
           dma_done_one_in, dma_done_two_in, mgmt_sync_in, comm_req_granted}, 8'hFC);
    sys_rst = 1'h0;
    cyc(1);
    t_port_c();
    t_port_d_dma();
    t_d29();
    t_gpio_sync();
    t_grant();
    finish_test();
  end

  initial begin
    #(5000 * 50);
    errors++;
    finish_test();
  end
endmodule : port_c_d_pin_function_mux_tb
